//--- inc/qpp_if.sv
// Serial link between the flash controller and the flash end.
// Assumes pulled-up io lines: an undriven line reads as one.
interface qpp_if;
  logic sclk;
  logic cs_n;
  logic [3:0] io_out;
  logic [3:0] io_oe_n;
  wire [3:0] io;

  assign io = (io_out & ~io_oe_n) | io_oe_n;

  modport host (
    output sclk,
    output cs_n,
    output io_out,
    output io_oe_n,
    input io
  );
  modport flash (
    input sclk,
    input cs_n,
    input io
  );
endinterface

//--- inc/qpp_pkg.sv
// Shared constants for both ends of the quad page program link.
// Assumes a 250 MHz system clock on both ends.
package qpp_pkg;
  // Command code and frame layout.
  localparam logic [7:0] QPP_CMD_QUAD_PROG = 8'h32;
  localparam int QPP_HDR_BITS = 32;
  localparam int QPP_PAGE_BITS = 8;
  localparam logic [7:0] QPP_PAGE_LAST = 8'hFF;
  // Protected regions are counted in thirty-seconds of the array.
  localparam logic [5:0] QPP_BP_REGIONS = 6'h20;
  // Timing: page_program_duration in ns, turned into clock cycles.
  localparam int QPP_CLK_NS = 4;
  localparam int QPP_PP_TIME_NS = 100000;
  localparam int QPP_PP_CYC = (QPP_PP_TIME_NS + QPP_CLK_NS - 1) / QPP_CLK_NS;
  localparam int QPP_SCLK_HALF = 16;
  // Output enables, active low, for io lines 3..0.
  localparam logic [3:0] QPP_OE_N_IDLE = 4'hF;
  localparam logic [3:0] QPP_OE_N_SINGLE = 4'hE;
  localparam logic [3:0] QPP_OE_N_QUAD = 4'h0;
  // Host register offsets on the Wishbone bus.
  localparam logic [7:0] QPP_REG_CTRL = 8'h00;
  localparam logic [7:0] QPP_REG_ADDR = 8'h04;
  localparam logic [7:0] QPP_REG_LEN = 8'h08;
  localparam logic [7:0] QPP_REG_SEED = 8'h0C;
  localparam logic [7:0] QPP_REG_STATUS = 8'h10;
  localparam logic [7:0] QPP_REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] QPP_REG_IRQ_MASK = 8'h18;
  // Field positions and reset values.
  localparam int QPP_CTRL_GO_BIT = 0;
  localparam int QPP_CTRL_ODD_BIT = 1;
  localparam int QPP_STAT_BUSY_BIT = 0;
  localparam int QPP_IRQ_DONE_BIT = 0;
  localparam logic [23:0] QPP_ADDR_RST = 24'h00_0000;
  localparam logic [9:0] QPP_LEN_RST = 10'h001;
  localparam logic [7:0] QPP_SEED_RST = 8'h00;
endpackage

//--- rtl/qpp_flash.sv
// Flash end of the quad page program command, with its memory array.
// Assumes link pins arrive asynchronously and sclk half periods last at
// least three system clocks; write unlock and protect bits come from
// the surrounding status logic.
//
// The Wishbone slave port and the placing of the registers were decided locally.
module qpp_flash
  import qpp_pkg::*;
#(
  parameter int AW = 16,
  parameter int PP_CYC = QPP_PP_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial link
  qpp_if.flash link,
  // Status inputs
  input wire logic quad_mode_allow_bit_i,
  input wire logic unlock_set_i,
  input wire logic [4:0] region_protect_bits_i,
  // Memory read port
  input wire logic [AW-1:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  // Status outputs
  output logic write_unlock_latch_o,
  output logic program_in_progress_flag_o,
  output logic prog_done_o,
  output logic prog_refused_o
);

  if (AW < 13 || AW > 24) begin : g_aw_bad
    $error("AW must lie between 13 and 24");
  end
  if (PP_CYC < 1) begin : g_pp_bad
    $error("PP_CYC must be at least one");
  end

  typedef enum logic [2:0] {
    FL_IDLE,
    FL_HDR,
    FL_DATA,
    FL_WAIT,
    FL_COPY
  } qpp_fl_e;

  qpp_fl_e state_reg;
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic [1:0] prev_reg;
  logic [4:0] bitcnt_reg;
  logic [31:0] hdr_reg;
  logic half_reg;
  logic [3:0] hi_reg;
  logic [7:0] col_reg;
  logic any_reg;
  logic [AW-9:0] page_reg;
  logic [255:0] mask_reg;
  logic [31:0] timer_reg;
  logic wel_reg;
  logic done_reg;
  logic refused_reg;
  logic [7:0] rd_data_reg;
  logic [7:0] pbuf [256];
  logic [7:0] mem [2**AW];

  wire cs_n_s = sync2_reg[5];
  wire sclk_s = sync2_reg[4];
  wire [3:0] io_s = sync2_reg[3:0];
  wire sclk_rise = sclk_s & ~prev_reg[0];
  wire cs_fall = ~cs_n_s & prev_reg[1];
  wire cs_rise = cs_n_s & ~prev_reg[1];
  wire take = sclk_rise & ~cs_n_s;
  wire busy = (state_reg == FL_WAIT) || (state_reg == FL_COPY);

  wire [31:0] hdr_next = {hdr_reg[30:0], io_s[0]};
  wire hdr_last = bitcnt_reg == 5'(QPP_HDR_BITS - 1);
  wire [7:0] byte_in = {hi_reg, io_s};
  wire cmd_ok = hdr_reg[31:24] == QPP_CMD_QUAD_PROG;
  wire [4:0] top5 = page_reg[AW-9 -: 5];
  wire [5:0] prot_floor = QPP_BP_REGIONS - {1'b0, region_protect_bits_i};
  wire prot = (region_protect_bits_i != 5'h00) &&
              ({1'b0, top5} >= prot_floor);
  wire frame_ok = (state_reg == FL_DATA) && any_reg && !half_reg &&
                  cmd_ok && quad_mode_allow_bit_i && wel_reg && !prot;
  wire timer_end = timer_reg == 32'(PP_CYC - 1);
  wire copy_last = col_reg == QPP_PAGE_LAST;
  wire pbuf_we = (state_reg == FL_DATA) && take && half_reg;
  wire mem_we = (state_reg == FL_COPY) && mask_reg[col_reg];

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= 6'h3F;
      sync2_reg <= 6'h3F;
      prev_reg <= 2'h3;
    end else begin
      sync1_reg <= {link.cs_n, link.sclk, link.io};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg[5:4];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= FL_IDLE;
      bitcnt_reg <= 5'h00;
      hdr_reg <= 32'h0000_0000;
      half_reg <= 1'b0;
      hi_reg <= 4'h0;
      col_reg <= 8'h00;
      any_reg <= 1'b0;
      page_reg <= '0;
      timer_reg <= 32'h0000_0000;
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
      case (state_reg)
        FL_IDLE: begin
          if (cs_fall) begin
            state_reg <= FL_HDR;
            bitcnt_reg <= 5'h00;
          end
        end
        FL_HDR: begin
          if (cs_rise) begin
            state_reg <= FL_IDLE;
            refused_reg <= 1'b1;
          end else if (take) begin
            hdr_reg <= hdr_next;
            bitcnt_reg <= bitcnt_reg + 5'h01;
            if (hdr_last) begin
              state_reg <= FL_DATA;
              page_reg <= hdr_next[AW-1:QPP_PAGE_BITS];
              col_reg <= hdr_next[7:0];
              half_reg <= 1'b0;
              any_reg <= 1'b0;
            end
          end
        end
        FL_DATA: begin
          if (cs_rise) begin
            if (frame_ok) begin
              state_reg <= FL_WAIT;
              timer_reg <= 32'h0000_0000;
            end else begin
              state_reg <= FL_IDLE;
              refused_reg <= 1'b1;
            end
          end else if (take) begin
            half_reg <= ~half_reg;
            if (!half_reg) begin
              hi_reg <= io_s;
            end else begin
              col_reg <= col_reg + 8'h01;
              any_reg <= 1'b1;
            end
          end
        end
        FL_WAIT: begin
          timer_reg <= timer_reg + 32'h0000_0001;
          if (timer_end) begin
            state_reg <= FL_COPY;
            col_reg <= 8'h00;
          end
        end
        FL_COPY: begin
          col_reg <= col_reg + 8'h01;
          if (copy_last) begin
            state_reg <= FL_IDLE;
            done_reg <= 1'b1;
          end
        end
        default: begin
          state_reg <= FL_IDLE;
        end
      endcase
    end
  end

  // Bytes already taken in this page count again when re-sent.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_reg <= '0;
    end else if ((state_reg == FL_HDR) && take && hdr_last) begin
      mask_reg <= '0;
    end else if (pbuf_we) begin
      mask_reg[col_reg] <= 1'b1;
    end
  end

  // A later byte at the same column replaces the earlier one.
  always_ff @(posedge clk_i) begin
    if (pbuf_we) begin
      pbuf[col_reg] <= byte_in;
    end
  end

  // Only columns that received data are written.
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem[{page_reg, col_reg}] <= pbuf[col_reg];
    end
  end

  always_ff @(posedge clk_i) begin
    rd_data_reg <= mem[rd_addr_i];
  end

  // The latch clears as the program starts unless unlock comes in that cycle; unlock is ignored while busy.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wel_reg <= 1'b0;
    end else if (unlock_set_i && !busy) begin
      wel_reg <= 1'b1;
    end else if (cs_rise && frame_ok) begin
      wel_reg <= 1'b0;
    end
  end

  assign rd_data_o = rd_data_reg;
  assign write_unlock_latch_o = wel_reg;
  assign program_in_progress_flag_o = busy;
  assign prog_done_o = done_reg;
  assign prog_refused_o = refused_reg;

endmodule

//--- rtl/qpp_host.sv
// Controller end: sends one quad page program frame per order.
// Assumes a classic Wishbone master and a flash end that already has
// quad mode and its write unlock latch set.
module qpp_host
  import qpp_pkg::*;
#(
  parameter int SCLK_HALF = QPP_SCLK_HALF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Interrupt
  output logic irq_o,
  // Serial link
  qpp_if.host link
);

  if (SCLK_HALF < 4 || SCLK_HALF > 255) begin : g_half_bad
    $error("SCLK_HALF must lie between 4 and 255");
  end

  typedef enum logic [1:0] {
    HS_IDLE,
    HS_SHIFT,
    HS_TAIL,
    HS_GAP
  } qpp_hs_e;

  qpp_hs_e state_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic [23:0] addr_reg;
  logic [9:0] len_reg;
  logic [7:0] seed_reg;
  logic odd_reg;
  logic irq_stat_reg;
  logic irq_mask_reg;
  logic [7:0] div_reg;
  logic [11:0] beat_reg;
  logic sclk_reg;
  logic cs_n_reg;
  logic [3:0] io_reg;
  logic [3:0] oe_n_reg;

  wire req = wb_cyc_i & wb_stb_i;
  wire wr = req & wb_we_i & ack_reg;
  wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                       {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] wdat = wb_dat_i & wmask;
  wire wr_ctrl = wr && (wb_adr_i == QPP_REG_CTRL) && wb_sel_i[0];
  wire go = wr_ctrl && wdat[QPP_CTRL_GO_BIT] && (state_reg == HS_IDLE) &&
            (len_reg != 10'h000);
  wire busy = state_reg != HS_IDLE;
  wire tick = div_reg == 8'(SCLK_HALF - 1);
  wire [11:0] total = 12'(QPP_HDR_BITS) + {1'b0, len_reg, 1'b0} +
                      {11'h000, odd_reg};
  wire [11:0] beat_nx = beat_reg + 12'h001;
  wire last_beat = beat_nx == total;
  wire [31:0] hdr = {QPP_CMD_QUAD_PROG, addr_reg};
  wire [11:0] k = beat_nx - 12'(QPP_HDR_BITS);
  // A second lap through the page adds one, so overwrites can be told apart.
  wire [7:0] dbyte = seed_reg + k[8:1] + {7'h00, k[9]};
  wire in_hdr = beat_nx < 12'(QPP_HDR_BITS);
  wire [3:0] nib = k[0] ? dbyte[3:0] : dbyte[7:4];
  wire [3:0] io_nx = in_hdr ? {3'h0, hdr[5'(31 - beat_nx[4:0])]} : nib;
  wire done_evt = (state_reg == HS_GAP) && tick;

  wire [31:0] rd_mux =
    (wb_adr_i == QPP_REG_ADDR) ? {8'h00, addr_reg} :
    (wb_adr_i == QPP_REG_LEN) ? {22'h00_0000, len_reg} :
    (wb_adr_i == QPP_REG_SEED) ? {24'h00_0000, seed_reg} :
    (wb_adr_i == QPP_REG_CTRL) ? {30'h0000_0000, odd_reg, 1'b0} :
    (wb_adr_i == QPP_REG_STATUS) ? {31'h0000_0000, busy} :
    (wb_adr_i == QPP_REG_IRQ_STAT) ? {31'h0000_0000, irq_stat_reg} :
    (wb_adr_i == QPP_REG_IRQ_MASK) ? {31'h0000_0000, irq_mask_reg} :
    32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req & ~ack_reg;
      rdat_reg <= rd_mux;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_reg <= QPP_ADDR_RST;
      len_reg <= QPP_LEN_RST;
      seed_reg <= QPP_SEED_RST;
      odd_reg <= 1'b0;
      irq_mask_reg <= 1'b0;
    end else if (wr) begin
      if (wb_adr_i == QPP_REG_ADDR) begin
        addr_reg <= (addr_reg & ~wmask[23:0]) | wdat[23:0];
      end
      if (wb_adr_i == QPP_REG_LEN) begin
        len_reg <= (len_reg & ~wmask[9:0]) | wdat[9:0];
      end
      if ((wb_adr_i == QPP_REG_SEED) && wb_sel_i[0]) begin
        seed_reg <= wdat[7:0];
      end
      if (wr_ctrl && !busy) begin
        odd_reg <= wdat[QPP_CTRL_ODD_BIT];
      end
      if ((wb_adr_i == QPP_REG_IRQ_MASK) && wb_sel_i[0]) begin
        irq_mask_reg <= wdat[QPP_IRQ_DONE_BIT];
      end
    end
  end

  // A new done event wins over a clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= 1'b0;
    end else if (done_evt) begin
      irq_stat_reg <= 1'b1;
    end else if (wr && (wb_adr_i == QPP_REG_IRQ_STAT) &&
                 wdat[QPP_IRQ_DONE_BIT]) begin
      irq_stat_reg <= 1'b0;
    end
  end

  // Data changes on the falling sclk edge; the flash samples on rising.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= HS_IDLE;
      div_reg <= 8'h00;
      beat_reg <= 12'h000;
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      io_reg <= 4'h0;
      oe_n_reg <= QPP_OE_N_IDLE;
    end else begin
      div_reg <= (tick || !busy) ? 8'h00 : div_reg + 8'h01;
      case (state_reg)
        HS_IDLE: begin
          if (go) begin
            state_reg <= HS_SHIFT;
            cs_n_reg <= 1'b0;
            beat_reg <= 12'h000;
            io_reg <= {3'h0, hdr[31]};
            oe_n_reg <= QPP_OE_N_SINGLE;
          end
        end
        HS_SHIFT: begin
          if (tick) begin
            sclk_reg <= ~sclk_reg;
            if (sclk_reg) begin
              beat_reg <= beat_nx;
              if (last_beat) begin
                state_reg <= HS_TAIL;
                oe_n_reg <= QPP_OE_N_IDLE;
              end else begin
                io_reg <= io_nx;
                oe_n_reg <= in_hdr ? QPP_OE_N_SINGLE : QPP_OE_N_QUAD;
              end
            end
          end
        end
        HS_TAIL: begin
          if (tick) begin
            state_reg <= HS_GAP;
            cs_n_reg <= 1'b1;
          end
        end
        HS_GAP: begin
          if (tick) begin
            state_reg <= HS_IDLE;
          end
        end
        default: begin
          state_reg <= HS_IDLE;
        end
      endcase
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign irq_o = irq_stat_reg & irq_mask_reg;
  assign link.sclk = sclk_reg;
  assign link.cs_n = cs_n_reg;
  assign link.io_out = io_reg;
  assign link.io_oe_n = oe_n_reg;

endmodule

//--- tb/qpp_link_assertions.sv
// Checker for the serial link joining the host end to the flash end.
// Assumes the link signals and the host clock and reset as plain inputs.
module qpp_link_assertions
  import qpp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link signals
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe_n,
  input wire logic [3:0] io
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Counts serial clock rises inside the current frame.
  logic sclk_q;
  logic [11:0] rise_cnt;
  logic [7:0] cmd_sh;
  wire sclk_rise = sclk & ~sclk_q;
  always_ff @(posedge clk_i) begin
    sclk_q <= sclk;
    rise_cnt <= cs_n ? 12'h000 : rise_cnt + {11'h000, sclk_rise};
  end

  // Collects the bits the host puts on line 0 at each rise.
  always_ff @(posedge clk_i) begin
    if (sclk_rise && !cs_n) begin
      cmd_sh <= {cmd_sh[6:0], io_out[0]};
    end
  end

  sequence s_frame_open;
    $fell(cs_n);
  endsequence
  sequence s_data_end;
    $rose(io_oe_n[0]) && !cs_n;
  endsequence

  a_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("serial clock not low while deselected");
  a_idle_lines_free: assert property (cs_n |->
    io_oe_n == QPP_OE_N_IDLE && io == 4'hF)
    else $error("io lines driven while deselected");
  a_header_single: assert property (s_frame_open |->
    io_oe_n == QPP_OE_N_SINGLE && io[0] == QPP_CMD_QUAD_PROG[7])
    else $error("frame does not open with command bit on line 0");
  a_io_hold_rise: assert property ($rose(sclk) |-> $stable(io))
    else $error("io changed at a serial clock rise");
  a_sclk_high_min: assert property ($rose(sclk) |-> sclk[*3])
    else $error("serial clock high phase too short");
  a_sclk_low_min: assert property (($fell(sclk) && !cs_n) |->
    (!sclk)[*3])
    else $error("serial clock low phase too short");
  a_quad_after_hdr: assert property ((io_oe_n == QPP_OE_N_QUAD) |->
    rise_cnt >= 12'h020)
    else $error("quad drive before the header ended");
  a_single_in_hdr: assert property ((!cs_n && rise_cnt < 12'h020) |->
    io_oe_n == QPP_OE_N_SINGLE)
    else $error("header not sent on line 0 alone");
  a_end_after_data: assert property ($rose(cs_n) |->
    rise_cnt > 12'h020)
    else $error("frame closed without data");
  a_cs_after_data: assert property (s_data_end |->
    ##[1:64] $rose(cs_n))
    else $error("select not raised after the last data beat");
  a_cmd_code: assert property (($rose(sclk) && rise_cnt == 12'h007) |=>
    cmd_sh == QPP_CMD_QUAD_PROG)
    else $error("command code on line 0 is wrong");
  a_cs_gap: assert property ($rose(cs_n) |=> cs_n[*3])
    else $error("gap between frames too short");
endmodule

//--- tb/quad_page_program_command_tb.sv
// Self-checking bench: host end and flash end joined by one link.
// Assumes the package, the link interface and both ends compiled first.
module quad_page_program_command_tb
  import qpp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PP = 50;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0] sel = 4'h0;
  logic [31:0] rdat;
  logic ack, irq, latch, flag, done, refused;
  logic qbit = 1'b1;
  logic unlock = 1'b0;
  logic [4:0] bp = 5'h00;
  logic [15:0] raddr = 16'h0000;
  logic [7:0] rdata;
  int err_total = 0;
  int num_checks = 0;

  always #2 clk = ~clk;

  qpp_if link_if ();
  qpp_host #(.SCLK_HALF(4)) qpp_host_inst (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq_o(irq), .link(link_if.host));
  qpp_flash #(.AW(16), .PP_CYC(PP)) qpp_flash_inst (
    .clk_i(clk), .rst_i(rst), .link(link_if.flash),
    .quad_mode_allow_bit_i(qbit), .unlock_set_i(unlock),
    .region_protect_bits_i(bp), .rd_addr_i(raddr), .rd_data_o(rdata),
    .write_unlock_latch_o(latch), .program_in_progress_flag_o(flag),
    .prog_done_o(done), .prog_refused_o(refused));
  qpp_link_assertions qpp_link_assertions_inst (
    .clk_i(clk), .rst_i(rst), .sclk(link_if.sclk), .cs_n(link_if.cs_n),
    .io_out(link_if.io_out), .io_oe_n(link_if.io_oe_n), .io(link_if.io));

  task automatic results;
    $display("Checks %0d, errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One classic Wishbone cycle; released only after ack is sampled.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do @(posedge clk); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    wb(1'b0, a, 32'h0000_0000, r);
    chk(r, exp, "register read");
  endtask

  task automatic mem(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    raddr <= a;
    repeat (2) @(posedge clk);
    chk(32'(rdata), 32'(exp), "array byte");
  endtask

  task automatic arm;
    @(posedge clk);
    unlock <= 1'b1;
    @(posedge clk);
    unlock <= 1'b0;
    @(posedge clk);
    chk(32'(latch), 32'h1, "unlock latch");
  endtask

  // Orders one frame, then judges how the flash end finished it.
  task automatic frame(input logic [15:0] a, input logic [9:0] n,
                       input logic [7:0] s, input logic odd, input logic ok);
    int busy;
    int k;
    logic bad;
    busy = 0;
    bad = 1'b0;
    wr(QPP_REG_ADDR, {16'h0000, a});
    wr(QPP_REG_LEN, {22'h00_0000, n});
    wr(QPP_REG_SEED, {24'h00_0000, s});
    wr(QPP_REG_CTRL, {30'h0000_0000, odd, 1'b1});
    rd(QPP_REG_STATUS, 32'h0000_0001);
    for (k = 0; k < 30000 && done !== 1'b1 && refused !== 1'b1; k++) begin
      @(posedge clk);
      if (flag === 1'b1) busy++;
      if (flag === 1'b1 && latch !== 1'b0) bad = 1'b1;
    end
    chk(32'(done), 32'(ok), "program done");
    chk(32'(refused), 32'(!ok), "program refused");
    chk(32'(bad), 32'h0, "latch kept while programming");
    chk(32'(ok ? busy >= PP && busy <= PP + 300 : busy == 0), 32'h1,
        "busy span");
    repeat (2) @(posedge clk);
    chk(32'(flag), 32'h0, "flag after program");
    rd(QPP_REG_STATUS, 32'h0000_0000);
  endtask

  task automatic t_regs;
    rd(QPP_REG_LEN, 32'h0000_0001);
    rd(QPP_REG_ADDR, 32'h0000_0000);
    rd(QPP_REG_SEED, 32'h0000_0000);
    rd(QPP_REG_STATUS, 32'h0000_0000);
    rd(QPP_REG_IRQ_STAT, 32'h0000_0000);
    rd(QPP_REG_IRQ_MASK, 32'h0000_0000);
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, 32'h0000_0000);
    wr(QPP_REG_SEED, 32'h0000_01A5);
    rd(QPP_REG_SEED, 32'h0000_00A5);
    rd(QPP_REG_CTRL, 32'h0000_0000);
  endtask

  // Runs past a page: columns 0 and 1 come from the second lap, one higher.
  task automatic t_full;
    arm();
    frame(16'h1300, 10'h102, 8'h10, 1'b0, 1'b1);
    mem(16'h1300, 8'h11);
    mem(16'h1301, 8'h12);
    mem(16'h137F, 8'h8F);
    mem(16'h13FF, 8'h0F);
  endtask

  task automatic t_part;
    arm();
    frame(16'h1380, 10'h002, 8'h00, 1'b0, 1'b1);
    mem(16'h137F, 8'h8F);
    mem(16'h1380, 8'h00);
    mem(16'h1381, 8'h01);
    mem(16'h1382, 8'h92);
    arm();
    frame(16'h13FF, 10'h002, 8'h55, 1'b0, 1'b1);
    mem(16'h13FF, 8'h55);
    mem(16'h1300, 8'h56);
    mem(16'h1301, 8'h12);
  endtask

  task automatic t_refuse;
    frame(16'h1310, 10'h001, 8'hEE, 1'b0, 1'b0);
    qbit <= 1'b0;
    arm();
    frame(16'h1310, 10'h001, 8'hEE, 1'b0, 1'b0);
    qbit <= 1'b1;
    bp <= 5'h1E;
    frame(16'h1310, 10'h001, 8'hEE, 1'b0, 1'b0);
    bp <= 5'h1D;
    frame(16'h1310, 10'h001, 8'hEE, 1'b1, 1'b0);
    mem(16'h1310, 8'h20);
    frame(16'h1310, 10'h001, 8'hEE, 1'b0, 1'b1);
    mem(16'h1310, 8'hEE);
  endtask

  task automatic t_irq;
    wr(QPP_REG_IRQ_MASK, 32'h0000_0000);
    @(posedge clk);
    chk(32'(irq), 32'h0, "masked interrupt");
    wr(QPP_REG_IRQ_MASK, 32'h0000_0001);
    @(posedge clk);
    chk(32'(irq), 32'h1, "raised interrupt");
    wr(QPP_REG_IRQ_STAT, 32'h0000_0001);
    @(posedge clk);
    chk(32'(irq), 32'h0, "cleared interrupt");
    rd(QPP_REG_IRQ_STAT, 32'h0000_0000);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_regs();
    t_full();
    t_part();
    t_refuse();
    t_irq();
    results();
  end

  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    $display("Error %0t: run did not finish", $time);
    results();
  end
endmodule
